/* File: src/suart_baud_gen.sv */
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module suart_baud_gen (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // first port clock output routing
  input wire logic first_port_generator_clock_out,
  output logic pin_p4_7_out,
  output logic pin_p4_4_out,
  // first port time base select
  output logic first_port_tx_uses_second_gen,
  output logic first_port_rx_uses_second_gen,
  // serial engine side
  input wire logic engine_tx_bit,
  output logic engine_rx_bit,
  output logic [2:0] engine_mode,
  output logic engine_shift_tick,
  output logic engine_bit_tick,
  output logic engine_rx_sample_tick,
  // pins
  input wire logic second_port_receive_line,
  output logic second_port_transmit_line,
  // generator outputs
  output logic baud_counter_overflow,
  output logic second_port_generator_clock_out
);
  import suart_pkg::*;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  logic [7:0] aux6;
  logic [7:0] next_aux6;
  logic [7:0] baud_reload_register;
  logic [7:0] next_baud_reload_register;
  logic [7:0] baud_counter;
  logic [7:0] next_baud_counter;
  logic cko;
  logic next_cko;
  logic change_flag;
  logic next_change_flag;
  logic rx_prev;
  logic next_rx_prev;
  logic tx_q;
  logic next_tx_q;
  logic [31:0] next_prdata;

  logic baud_generator_run;
  logic generator_clock_speed_select;
  logic double_rate_select;
  logic mode2_times_three_select;
  logic timer_mode;
  logic [2:0] mode;
  logic wr;
  logic rd;
  logic mapped;
  logic gen_tick;
  logic mode13;
  logic mode04;
  logic mode2;
  logic [7:0] gen_div;
  logic [7:0] shift_div;
  logic [7:0] mode2_div;
  logic [7:0] sample_div;
  logic sample_tick;
  logic bit13_tick;
  logic mode2_tick;
  logic [3:0] shift_age;
  logic [3:0] next_shift_age;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction : merge8

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_RELOAD) || (paddr == ADDR_COUNT)
    || (paddr == ADDR_STATUS) || (paddr == ADDR_AUX6);
  // zero wait states keeps the register path a single cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign baud_generator_run = ctrl[CTRL_RUN];
  assign generator_clock_speed_select = ctrl[CTRL_SPEED];
  assign double_rate_select = ctrl[CTRL_DOUBLE];
  assign mode2_times_three_select = ctrl[CTRL_X3];
  assign mode = ctrl[CTRL_MODE_LO +: 3];
  assign timer_mode = ctrl[CTRL_TIMER];

  // ----------------------------------------
  // generator prescale and overflow
  // ----------------------------------------
  assign gen_div = generator_clock_speed_select ? DIV_BY1 : DIV_BY12;

  suart_tick_div #(.W(8)) u_gen_pre (
    .pclk(pclk),
    .presetn(presetn),
    .en(baud_generator_run),
    .div(gen_div),
    .tick(gen_tick)
  );

  // overflow runs in every mode so peripherals keep their time base
  assign baud_counter_overflow = gen_tick && (baud_counter == 8'hFF);

  // ----------------------------------------
  // mode dependent ticks
  // ----------------------------------------
  assign mode13 = (mode == MODE_UART8) || (mode == MODE_UART9);
  assign mode04 = (mode == MODE_SHIFT) || (mode == MODE_SPI);
  assign mode2 = (mode == MODE_UART9F);
  assign shift_div = generator_clock_speed_select ? DIV_MODE0_FAST : DIV_BY12;

  always_comb begin
    unique case ({double_rate_select, mode2_times_three_select})
      2'b00: mode2_div = DIV_MODE2;
      2'b10: mode2_div = DIV_MODE2_DBL;
      2'b01: mode2_div = DIV_MODE2_X3;
      2'b11: mode2_div = DIV_MODE2_DBL_X3;
    endcase
  end

  // sixteen samples a bit: without double rate a sample is two overflows
  assign sample_div = double_rate_select ? DIV_BY1 : DIV_SAMPLE_HALF;

  suart_tick_div #(.W(8)) u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .en(mode04),
    .div(shift_div),
    .tick(engine_shift_tick)
  );

  suart_tick_div #(.W(8)) u_mode2 (
    .pclk(pclk),
    .presetn(presetn),
    .en(mode2),
    .div(mode2_div),
    .tick(mode2_tick)
  );

  suart_tick_div #(.W(8)) u_sample (
    .pclk(pclk),
    .presetn(presetn),
    .en(baud_counter_overflow && mode13),
    .div(sample_div),
    .tick(sample_tick)
  );

  suart_tick_div #(.W(8)) u_bit (
    .pclk(pclk),
    .presetn(presetn),
    .en(sample_tick),
    .div(DIV_BIT_SAMPLES),
    .tick(bit13_tick)
  );

  assign engine_rx_sample_tick = sample_tick;
  assign engine_bit_tick = mode13 ? bit13_tick : mode2_tick;
  // engine has no framing check nor address match, only mode and ticks
  assign engine_mode = mode;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_aux6 = aux6;
    next_baud_reload_register = baud_reload_register;
    next_baud_counter = baud_counter;
    next_cko = cko;
    next_change_flag = change_flag;
    next_rx_prev = second_port_receive_line;
    next_tx_q = engine_tx_bit;
    next_prdata = prdata;
    if (gen_tick) begin
      next_baud_counter = baud_counter_overflow ? baud_reload_register : baud_counter + 8'h01;
    end
    if (baud_counter_overflow) begin
      next_cko = !cko;
    end
    if (wr && (paddr == ADDR_CTRL)) begin
      if (pstrb[0]) begin
        next_ctrl[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        next_ctrl[CTRL_W-1:8] = pwdata[CTRL_W-1:8];
      end
    end
    if (wr && (paddr == ADDR_AUX6)) begin
      next_aux6 = merge8(aux6, pwdata, pstrb);
    end
    if (wr && (paddr == ADDR_RELOAD)) begin
      next_baud_reload_register = merge8(baud_reload_register, pwdata, pstrb);
      if (!baud_generator_run) begin
        next_baud_counter = merge8(baud_counter, pwdata, pstrb);
      end
    end
    if (wr && (paddr == ADDR_COUNT)) begin
      next_baud_counter = merge8(baud_counter, pwdata, pstrb);
    end
    if (wr && (paddr == ADDR_STATUS) && pstrb[0] && pwdata[STAT_CHANGE]) begin
      next_change_flag = 1'b0;
    end
    // a change in the clearing cycle still sets the flag
    if (timer_mode && (second_port_receive_line != rx_prev)) begin
      next_change_flag = 1'b1;
    end
    // shift spacing watch; a control change voids it, the prescaler phase is then unknown
    next_shift_age = (shift_age == 4'hF) ? shift_age : shift_age + 4'h1;
    if (engine_shift_tick) begin
      next_shift_age = 4'h0;
    end
    if (next_ctrl != ctrl) begin
      next_shift_age = 4'hF;
    end
    if (rd && !penable) begin
      next_prdata = 32'h0000_0000;
      unique case (1'b1)
        paddr == ADDR_CTRL: next_prdata[CTRL_W-1:0] = ctrl;
        paddr == ADDR_RELOAD: next_prdata[7:0] = baud_reload_register;
        paddr == ADDR_COUNT: next_prdata[7:0] = baud_counter;
        paddr == ADDR_STATUS: next_prdata[2:0] = {baud_generator_run, cko, change_flag};
        paddr == ADDR_AUX6: next_prdata[7:0] = aux6;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      aux6 <= AUX6_RESET;
      baud_reload_register <= RELOAD_RESET;
      baud_counter <= COUNT_RESET;
      cko <= 1'b0;
      change_flag <= 1'b0;
      rx_prev <= 1'b1;
      tx_q <= 1'b1;
      prdata <= 32'h0000_0000;
      shift_age <= 4'hF;
    end else begin
      ctrl <= next_ctrl;
      aux6 <= next_aux6;
      baud_reload_register <= next_baud_reload_register;
      baud_counter <= next_baud_counter;
      cko <= next_cko;
      change_flag <= next_change_flag;
      rx_prev <= next_rx_prev;
      tx_q <= next_tx_q;
      prdata <= next_prdata;
      shift_age <= next_shift_age;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign second_port_generator_clock_out = cko;
  assign second_port_transmit_line = tx_q;
  assign engine_rx_bit = second_port_receive_line;
  // both ports are independent; only the time base choice links them
  assign first_port_tx_uses_second_gen = ctrl[CTRL_P0_TX];
  assign first_port_rx_uses_second_gen = ctrl[CTRL_P0_RX];
  // unselected pin idles low
  assign pin_p4_7_out = !aux6[AUX6_CKO_PIN] && first_port_generator_clock_out;
  assign pin_p4_4_out = aux6[AUX6_CKO_PIN] && first_port_generator_clock_out;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_pin_route: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_p4_4_out == (aux6[0] && first_port_generator_clock_out)) && !(pin_p4_4_out && pin_p4_7_out))
    else $error("clock output pin routing wrong");

  chk_reload_stopped: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == ADDR_RELOAD) && pstrb[0] && !baud_generator_run
    |=> (baud_counter == $past(pwdata[7:0])) && (baud_reload_register == baud_counter))
    else $error("reload write while stopped missed counter");

  chk_reload_running: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == ADDR_RELOAD) && baud_generator_run && !gen_tick |=> $stable(baud_counter))
    else $error("reload write disturbed running counter");

  chk_count_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && (paddr == ADDR_COUNT) |=> $stable(baud_reload_register))
    else $error("counter write changed reload");

  chk_ovf_reload: assert property (@(posedge pclk) disable iff (!presetn)
    baud_counter_overflow && !(wr && (paddr == ADDR_COUNT || paddr == ADDR_RELOAD))
    |=> baud_counter == $past(baud_reload_register))
    else $error("overflow did not reload");

  chk_cko_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    baud_counter_overflow |=> (cko != $past(cko)))
    else $error("clock output missed toggle");

  chk_hold_stopped: assert property (@(posedge pclk) disable iff (!presetn)
    !baud_generator_run && !wr |=> $stable(baud_counter) && !$past(baud_counter_overflow))
    else $error("counter moved while stopped");

  chk_fast_count: assert property (@(posedge pclk) disable iff (!presetn)
    baud_generator_run && generator_clock_speed_select |-> gen_tick)
    else $error("fast prescale not every cycle");

  chk_mode0_gap: assert property (@(posedge pclk) disable iff (!presetn)
    engine_shift_tick && !generator_clock_speed_select && (shift_age != 4'hF)
    |-> ({4'h0, shift_age} == (DIV_BY12 - 8'h01)))
    else $error("mode zero shift spacing wrong");

  chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    timer_mode && (second_port_receive_line != rx_prev) |=> change_flag)
    else $error("port change lost");

  chk_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !mapped |-> pslverr && pready)
    else $error("unmapped access not flagged");
endmodule : suart_baud_gen

/* File: src/suart_pkg.sv */
// Notes on behaviour
// - first port clock output goes to pin 4.7 when select is 0, pin 4.4 when 1
// - second port offers modes zero to four, like the first port
// - no framing error detection and no address recognition on second port
// - second port sends on its own transmit line, receives on its own line
// - port plus generator can run as 8-bit auto-reload timer with change detect
// - in modes 0 and 4 speed select acts as the times-three mode-zero control
// - both ports run at once, any modes and any rates
// - 8-bit up-counter reloads from 8-bit reload register on each overflow
// - overflow pulse is the bit time base in modes 1 and 3
// - while stopped, writing reload also writes the counter
// - while running, reload write leaves counter; counter write never touches reload
// - software can pick this overflow as the first port time base
// - clock output toggles on every overflow, half the overflow rate
// - overflow keeps feeding other peripherals whether engine is busy or idle
// - modes 1,3 rate is 2^double/32 times clk/12 or clk over 256-reload
// - mode 0 shifts at clk/12 with speed select 0, clk/4 with 1
// - mode 2 rate is clk/64, doubled by double bit, thirded by times-three bit
package suart_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_RELOAD = 12'h004;
  localparam logic [11:0] ADDR_COUNT = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_AUX6 = 12'h0A4;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SPEED = 1;
  localparam int CTRL_DOUBLE = 2;
  localparam int CTRL_X3 = 3;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_TIMER = 7;
  localparam int CTRL_P0_TX = 8;
  localparam int CTRL_P0_RX = 9;
  localparam int CTRL_W = 10;
  localparam int AUX6_CKO_PIN = 0;
  localparam int STAT_CHANGE = 0;
  localparam int STAT_CKO = 1;
  localparam int STAT_RUN = 2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
  localparam logic [7:0] AUX6_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // ----------------------------------------
  // modes and divisors
  // ----------------------------------------
  localparam logic [2:0] MODE_SHIFT = 3'h0;
  localparam logic [2:0] MODE_UART8 = 3'h1;
  localparam logic [2:0] MODE_UART9F = 3'h2;
  localparam logic [2:0] MODE_UART9 = 3'h3;
  localparam logic [2:0] MODE_SPI = 3'h4;
  localparam logic [7:0] DIV_BY12 = 8'h0C;
  localparam logic [7:0] DIV_BY1 = 8'h01;
  localparam logic [7:0] DIV_MODE0_FAST = 8'h04;
  localparam logic [7:0] DIV_MODE2 = 8'h40;
  localparam logic [7:0] DIV_MODE2_DBL = 8'h20;
  localparam logic [7:0] DIV_MODE2_X3 = 8'hC0;
  localparam logic [7:0] DIV_MODE2_DBL_X3 = 8'h60;
  localparam logic [7:0] DIV_SAMPLE_HALF = 8'h02;
  localparam logic [7:0] DIV_BIT_SAMPLES = 8'h10;
endpackage : suart_pkg

/* File: src/suart_tick_div.sv */
`timescale 1ns/1ps
module suart_tick_div #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // count enable and divisor
  input wire logic en,
  input wire logic [W-1:0] div,
  // one pulse every div enables
  output logic tick
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic wrap;

  // divisor 0 behaves as 1 so the tick never stalls
  assign wrap = (div <= W'(1)) || (cnt >= div - W'(1));
  assign tick = en && wrap;

  always_comb begin
    next_cnt = cnt;
    if (en) begin
      next_cnt = wrap ? '0 : cnt + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule : suart_tick_div

/* File: verif/suart_remote_model.sv */
`timescale 1ns/1ps
module suart_remote_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // line from the device
  input wire logic tx_line,
  // bench command to flip the line
  input wire logic toggle_req,
  // line to the device, last value heard
  output logic rx_line,
  output logic tx_seen
);
  logic next_rx_line;
  logic next_tx_seen;
  always_comb begin
    next_rx_line = rx_line ^ toggle_req;
    next_tx_seen = tx_line;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // idle mark level, as a real far end would hold it
      rx_line <= 1'b1;
      tx_seen <= 1'b1;
    end else begin
      rx_line <= next_rx_line;
      tx_seen <= next_tx_seen;
    end
  end
endmodule : suart_remote_model

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import suart_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic fp_cko, p47, p44, tx_use, rx_use, engine_tx_bit, engine_rx_bit;
  logic [2:0] engine_mode;
  logic shift_tick, bit_tick, sample_tick, rx_line, tx_line, ovf, cko, cko_q, toggle_req, tx_seen;
  int fail_count = 0;
  int n_tests = 0;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) cko_q <= cko;
  suart_baud_gen u_suart_baud_gen (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_port_generator_clock_out(fp_cko), .pin_p4_7_out(p47), .pin_p4_4_out(p44),
    .first_port_tx_uses_second_gen(tx_use), .first_port_rx_uses_second_gen(rx_use),
    .engine_tx_bit(engine_tx_bit), .engine_rx_bit(engine_rx_bit), .engine_mode(engine_mode),
    .engine_shift_tick(shift_tick), .engine_bit_tick(bit_tick), .engine_rx_sample_tick(sample_tick),
    .second_port_receive_line(rx_line), .second_port_transmit_line(tx_line),
    .baud_counter_overflow(ovf), .second_port_generator_clock_out(cko));
  suart_remote_model u_suart_remote_model (.pclk(pclk), .presetn(presetn), .tx_line(tx_line),
    .toggle_req(toggle_req), .rx_line(rx_line), .tx_seen(tx_seen));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val
  task check_n(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_n
  task test_done;
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin fail_count++; test_done(); end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  function logic ev(input int k);
    case (k)
      0: ev = ovf;
      1: ev = shift_tick;
      2: ev = bit_tick;
      3: ev = sample_tick;
      default: ev = cko ^ cko_q;
    endcase
  endfunction : ev
  // cycles between two events; the first one only aligns us
  task measure(input int k, output int n);
    int i;
    i = 0;
    do begin @(posedge pclk); i++; end while (ev(k) !== 1'b1 && i < 3000);
    n = 0;
    do begin @(posedge pclk); n++; end while (ev(k) !== 1'b1 && n < 3000);
    if (n >= 3000) begin fail_count++; test_done(); end
  endtask : measure
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task test_reset;
    logic [31:0] r;
    logic e;
    logic [11:0] al [5] = '{ADDR_CTRL, ADDR_RELOAD, ADDR_COUNT, ADDR_STATUS, ADDR_AUX6};
    foreach (al[i]) begin rd(al[i], r); check_val(r, 32'h0000_0000); end
    check_val(tx_line, 1'b1);
    apb(1'b0, 12'h010, 32'h0, r, e);
    check_val(e, 1'b1);
    check_val(r, 32'h0000_0000);
    apb(1'b1, 12'h010, 32'h0000_00FF, r, e);
    check_val(e, 1'b1);
    $display("test reset done");
  endtask : test_reset
  task test_reload;
    logic [31:0] r, c1;
    wr(ADDR_RELOAD, 32'h0000_00F0);
    rd(ADDR_COUNT, r); check_val(r, 32'h0000_00F0);
    wr(ADDR_COUNT, 32'h0000_0033);
    rd(ADDR_RELOAD, r); check_val(r, 32'h0000_00F0);
    wr(ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_RELOAD, 32'h0000_0010);
    rd(ADDR_COUNT, r); check_val(r[7:0] == 8'h33 || r[7:0] == 8'h34, 1'b1);
    wr(ADDR_CTRL, 32'h0000_0000);
    rd(ADDR_COUNT, c1);
    repeat (40) @(posedge pclk);
    rd(ADDR_COUNT, r); check_val(r, c1);
    $display("test reload done");
  endtask : test_reload
  task test_rates;
    int n;
    wr(ADDR_RELOAD, 32'h0000_00F0);
    wr(ADDR_CTRL, 32'h0000_0003);
    measure(0, n); check_n(n, 16);
    measure(4, n); check_n(n, 16);
    wr(ADDR_CTRL, 32'h0000_0001);
    measure(0, n); check_n(n, 192);
    measure(0, n); check_n(n, 192);
    $display("test rates done");
  endtask : test_rates
  task test_fixed;
    int n;
    logic [31:0] c0 [4] = '{32'h000, 32'h002, 32'h040, 32'h042};
    int e0 [4] = '{12, 4, 12, 4};
    logic [31:0] c2 [4] = '{32'h020, 32'h024, 32'h028, 32'h02C};
    int e2 [4] = '{64, 32, 192, 96};
    foreach (c0[i]) begin wr(ADDR_CTRL, c0[i]); measure(1, n); check_n(n, e0[i]); end
    foreach (c2[i]) begin wr(ADDR_CTRL, c2[i]); measure(2, n); check_n(n, e2[i]); end
    $display("test fixed done");
  endtask : test_fixed
  task test_mode13;
    int n;
    logic [31:0] cv [4] = '{32'h013, 32'h017, 32'h033, 32'h037};
    int es [4] = '{8, 4, 8, 4};
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_RELOAD, 32'h0000_00FC);
    foreach (cv[i]) begin
      wr(ADDR_CTRL, cv[i]);
      // the write lands at the edge the task returns on, so look one edge later
      @(posedge pclk);
      check_val(engine_mode, cv[i][6:4]);
      measure(3, n); check_n(n, es[i]);
      measure(2, n); check_n(n, 16 * es[i]);
    end
    $display("test mode13 done");
  endtask : test_mode13
  task test_pins;
    logic [31:0] r;
    fp_cko <= 1'b1;
    wr(ADDR_AUX6, 32'h0000_00A4);
    rd(ADDR_AUX6, r); check_val(r, 32'h0000_00A4);
    check_val({p47, p44}, 2'b10);
    wr(ADDR_AUX6, 32'h0000_0001);
    @(posedge pclk); check_val({p47, p44}, 2'b01);
    wr(ADDR_CTRL, 32'h0000_0100);
    @(posedge pclk); check_val({tx_use, rx_use}, 2'b10);
    wr(ADDR_CTRL, 32'h0000_0200);
    @(posedge pclk); check_val({tx_use, rx_use}, 2'b01);
    engine_tx_bit <= 1'b0;
    @(posedge pclk); check_val(tx_line, 1'b1);
    @(posedge pclk); check_val(tx_line, 1'b0);
    @(posedge pclk); check_val(tx_seen, 1'b0);
    check_val(engine_rx_bit, rx_line);
    $display("test pins done");
  endtask : test_pins
  task flip_rx;
    toggle_req <= 1'b1;
    @(posedge pclk);
    toggle_req <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : flip_rx
  task test_change;
    logic [31:0] r;
    wr(ADDR_CTRL, 32'h0000_0000);
    flip_rx();
    rd(ADDR_STATUS, r); check_val(r[0], 1'b0);
    check_val(engine_rx_bit, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0080);
    flip_rx();
    rd(ADDR_STATUS, r); check_val(r[0], 1'b1);
    wr(ADDR_STATUS, 32'h0000_0001);
    rd(ADDR_STATUS, r); check_val(r[0], 1'b0);
    $display("test change done");
  endtask : test_change
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    fp_cko = 1'b0;
    engine_tx_bit = 1'b1;
    toggle_req = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_reload();
    test_rates();
    test_fixed();
    test_mode13();
    test_pins();
    test_change();
    test_done();
  end
endmodule : testbench
